// *** verilog/crcb_cfg.svh ***
// Constants of the byte-serial CRC-16 calculator
// Contract
// - Remainder of division by x^16+x^12+x^5+1
// - One 16-bit code over any byte count
// - Seed result first, then each byte updates
// - Each byte folded within two clock cycles
// - New remainder visible third cycle after a write into an empty FIFO
// - Input byte bit-reversed before use
// - Reversed byte, sixteen zeros, xor, divide
// - Result register holds remainder bit-reversed
`ifndef CRCB_CFG_SVH
`define CRCB_CFG_SVH

// ==========================================================
// Arithmetic
// ==========================================================
`define CRCB_POLY 16'h1021
`define CRCB_RESULT_RESET 16'h0000
`define CRCB_HOLD_RESET 8'h00

// ==========================================================
// Buffering
// ==========================================================
`define CRCB_FIFO_WIDTH 8
`define CRCB_FIFO_DEPTH 16

`endif

// *** verilog/crcb_pkg.sv ***
// Types shared by the CRC-16 calculator
package crcb_pkg;
   // Engine states, one-hot
   typedef enum logic [1:0] {
      CRCB_IDLE = 2'b01,
      CRCB_FOLD = 2'b10
   } crcb_state_t;

   // A write strobe with its data byte
   typedef struct packed {
      logic we;
      logic [7:0] data;
   } crcb_byte_wr_t;

   // A write strobe with a 16-bit seed
   typedef struct packed {
      logic we;
      logic [15:0] data;
   } crcb_seed_wr_t;
endpackage : crcb_pkg

// *** verilog/crcb_top.sv ***
// Byte FIFO and CRC-16 engine with the result and input registers
`timescale 1ns/1ns
`include "crcb_cfg.svh"

// ==========================================================
// Byte FIFO
// ==========================================================
module crcb_fifo #(
   parameter int WIDTH = `CRCB_FIFO_WIDTH,
   parameter int DEPTH = `CRCB_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];   // Flip-flop storage
   logic [AW-1:0] wr_ptr;           // Next slot to fill
   logic [AW-1:0] rd_ptr;           // Oldest slot
   logic [AW:0] count;              // Occupancy
   logic push;
   logic pop;

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage is not reset: only slots already written are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers wrap naturally since depth is a power of two
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   // Occupancy; simultaneous push and pop leave it unchanged
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
      end else if (push && !pop) begin
         count <= count + 1'b1;
      end else if (pop && !push) begin
         count <= count - 1'b1;
      end
   end

   // Occupancy never passes the depth
   fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
      count <= (AW+1)'(DEPTH))
      else $error("fifo occupancy above depth");
endmodule : crcb_fifo

// ==========================================================
// Calculator top
// ==========================================================
module crcb_top (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire crcb_pkg::crcb_seed_wr_t SEED_WR,
   input wire crcb_pkg::crcb_byte_wr_t BYTE_WR,
   output logic BYTE_READY,
   output logic [15:0] RESULT,
   output logic BUSY
);
   // Bit reversal of a byte
   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7-i];
      end
      return r;
   endfunction : rev8

   // Bit reversal of a word
   function automatic logic [15:0] rev16(input logic [15:0] v);
      logic [15:0] r;
      r = '0;
      for (int i = 0; i < 16; i++) begin
         r[i] = v[15-i];
      end
      return r;
   endfunction : rev16

   // Long division of (byte followed by 16 zeros) xor remainder, MSB first
   function automatic logic [15:0] crc_step(input logic [15:0] rem, input logic [7:0] dv);
      logic [15:0] r;
      r = rem ^ {dv, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[15] ? ({r[14:0], 1'b0} ^ `CRCB_POLY) : {r[14:0], 1'b0};
      end
      return r;
   endfunction : crc_step

   crcb_pkg::crcb_state_t state;    // Engine state
   logic [7:0] hold;                // Reversed byte being folded
   logic [15:0] crc_result_reg;     // Remainder, stored bit-reversed
   logic [7:0] fifo_data;
   logic fifo_valid;
   logic pop;

   // ==========================================================
   // Input buffering
   // ==========================================================
   // The buffer absorbs bursts: the engine drains one byte per two cycles
   crcb_fifo #(
      .WIDTH(`CRCB_FIFO_WIDTH),
      .DEPTH(`CRCB_FIFO_DEPTH)
   ) u_fifo (
      .clk(MCLK),
      .rst_n(RST_N),
      .in_valid(BYTE_WR.we),
      .in_ready(BYTE_READY),
      .in_data(BYTE_WR.data),
      .out_valid(fifo_valid),
      .out_ready(state == crcb_pkg::CRCB_IDLE),
      .out_data(fifo_data)
   );
   assign pop = fifo_valid && (state == crcb_pkg::CRCB_IDLE);

   // ==========================================================
   // Engine
   // ==========================================================
   // First cycle takes and reverses the byte, second cycle folds it
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= crcb_pkg::CRCB_IDLE;
      end else begin
         case (state)
            crcb_pkg::CRCB_IDLE: begin
               if (pop) begin
                  state <= crcb_pkg::CRCB_FOLD;
               end
            end
            crcb_pkg::CRCB_FOLD: begin
               state <= crcb_pkg::CRCB_IDLE;
            end
            default: begin
               state <= crcb_pkg::CRCB_IDLE;
            end
         endcase
      end
   end

   // Reversed byte latch
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         hold <= `CRCB_HOLD_RESET;
      end else if (pop) begin
         hold <= rev8(fifo_data);
      end
   end

   // Result register; a seed write wins over a finishing fold
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         crc_result_reg <= `CRCB_RESULT_RESET;
      end else if (SEED_WR.we) begin
         crc_result_reg <= SEED_WR.data;
      end else if (state == crcb_pkg::CRCB_FOLD) begin
         // Work in normal order, store reversed
         crc_result_reg <= rev16(crc_step(rev16(crc_result_reg), hold));
      end
   end

   assign RESULT = crc_result_reg;
   assign BUSY = (state != crcb_pkg::CRCB_IDLE) || fifo_valid;

   // ==========================================================
   // Checks
   // ==========================================================
   // Byte 0x01 on seed zero gives the known reversed code 0x1189
   known_vector_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state == crcb_pkg::CRCB_FOLD && hold == 8'h80 && crc_result_reg == 16'h0000
       && !SEED_WR.we) |=> RESULT == 16'h1189)
      else $error("known vector mismatch");

   // Bit 0 of the result carries the remainder's top bit
   reversed_out_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state == crcb_pkg::CRCB_FOLD && hold == 8'h80 && crc_result_reg == 16'h0000
       && !SEED_WR.we) |=> RESULT[0] == 1'b1 && RESULT[15] == 1'b0)
      else $error("result not bit-reversed");

   // A zero byte on a zero remainder stays zero
   zero_extend_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state == crcb_pkg::CRCB_FOLD && hold == 8'h00 && crc_result_reg == 16'h0000
       && !SEED_WR.we) |=> RESULT == 16'h0000)
      else $error("zero fold not zero");

   // Engine takes exactly two cycles per byte
   two_cycle_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      pop |=> state == crcb_pkg::CRCB_FOLD ##1 state == crcb_pkg::CRCB_IDLE)
      else $error("fold not two cycles");

   // Write into an idle empty path folds at the third edge
   third_cycle_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (BYTE_WR.we && !fifo_valid && state == crcb_pkg::CRCB_IDLE)
      |=> pop ##1 state == crcb_pkg::CRCB_FOLD)
      else $error("third cycle timing broken");

   // The latched byte is the reverse of the popped one
   byte_reverse_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      pop |=> hold[7] == $past(fifo_data[0]) && hold[6] == $past(fifo_data[1])
       && hold[5] == $past(fifo_data[2]) && hold[4] == $past(fifo_data[3])
       && hold[3] == $past(fifo_data[4]) && hold[2] == $past(fifo_data[5])
       && hold[1] == $past(fifo_data[6]) && hold[0] == $past(fifo_data[7]))
      else $error("byte not reversed");

   // Seed write replaces the result on the next edge
   seed_load_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      SEED_WR.we |=> RESULT == $past(SEED_WR.data))
      else $error("seed not loaded");

   // Result only changes by seed or fold
   result_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (!SEED_WR.we && state != crcb_pkg::CRCB_FOLD) |=> $stable(RESULT))
      else $error("result changed without cause");
endmodule : crcb_top

// *** dv/crcb_top_tb.sv ***
// Self-checking testbench for the byte-serial CRC-16 calculator
`timescale 1ns/1ns
module crcb_top_tb;
   // ==========================================================
   // Signals
   // ==========================================================
   logic MCLK; // 250 MHz clock
   logic RST_N; // Active-low reset
   crcb_pkg::crcb_seed_wr_t SEED_WR; // Seed strobe and value
   crcb_pkg::crcb_byte_wr_t BYTE_WR; // Byte strobe and value
   logic BYTE_READY; // FIFO has room
   logic [15:0] RESULT; // Bit-reversed remainder
   logic BUSY; // Bytes queued or folding
   int fail_count = 0; // Mismatches seen
   int samples_checked = 0; // Comparisons made
   logic [15:0] model; // Expected result register

   crcb_top dut (
      .MCLK(MCLK),
      .RST_N(RST_N),
      .SEED_WR(SEED_WR),
      .BYTE_WR(BYTE_WR),
      .BYTE_READY(BYTE_READY),
      .RESULT(RESULT),
      .BUSY(BUSY)
   );

   // Clock inverts every half period
   initial MCLK = 1'b0;
   always #2 MCLK = ~MCLK;

   // ==========================================================
   // Reference and helpers
   // ==========================================================
   // Reflected form: 8408 is 1021 bit-reversed, so folding here equals
   // reversing the byte, dividing MSB-first and reversing the remainder
   function automatic logic [15:0] fold(input logic [15:0] r, input logic [7:0] b);
      logic [15:0] x;
      x = r ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         x = x[0] ? ((x >> 1) ^ 16'h8408) : (x >> 1);
      end
      return x;
   endfunction : fold

   // Inputs change one ns after each rising edge
   task automatic step();
      @(posedge MCLK);
      #1;
   endtask : step

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask : chk

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   // Bounded wait; a hang counts as a mismatch and ends the run
   task automatic wait_idle();
      int n;
      n = 0;
      while (BUSY !== 1'b0) begin
         step();
         n++;
         if (n > 200) begin
            chk("idle wait", 16'h0000, 16'h0001);
            results();
         end
      end
   endtask : wait_idle

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic seed(input logic [15:0] s);
      SEED_WR = '{we: 1'b1, data: s};
      step();
      SEED_WR.we = 1'b0;
      model = s;
      chk("seed readback", s, RESULT);
   endtask : seed

   // Single byte on an idle engine: busy in c1, old value in c2, new in c3
   task automatic one_byte(input logic [7:0] b);
      BYTE_WR = '{we: 1'b1, data: b};
      step();
      BYTE_WR.we = 1'b0;
      chk("busy c1", 16'h0001, {15'h0000, BUSY});
      step();
      chk("result c2", model, RESULT);
      step();
      model = fold(model, b);
      chk("result c3", model, RESULT);
   endtask : one_byte

   // A seed landing on the fold edge wins and the byte is lost
   task automatic seed_clash(input logic [15:0] s);
      BYTE_WR = '{we: 1'b1, data: 8'h5A};
      step();
      BYTE_WR.we = 1'b0;
      step();
      SEED_WR = '{we: 1'b1, data: s};
      step();
      SEED_WR.we = 1'b0;
      model = s;
      chk("seed over fold", model, RESULT);
      wait_idle();
      chk("seed kept", model, RESULT);
   endtask : seed_clash

   // Back-to-back writes overrun the drain rate; a refused byte is held until taken
   task automatic burst(input int n, input logic [7:0] d0);
      logic full;
      int tries;
      full = 1'b0;
      for (int i = 0; i < n; i++) begin
         BYTE_WR = '{we: 1'b1, data: d0 + 8'(i * 7)};
         tries = 0;
         #2;
         // Refusal lasts one cycle while the engine drains, so the bound is small
         while (BYTE_READY !== 1'b1 && tries < 8) begin
            full = 1'b1;
            step();
            #2;
            tries++;
         end
         if (BYTE_READY !== 1'b1) begin
            chk("ready wait", 16'h0001, 16'h0000);
            results();
         end
         model = fold(model, BYTE_WR.data);
         step();
      end
      BYTE_WR.we = 1'b0;
      chk("fifo refused", {15'h0000, n > 20}, {15'h0000, full});
      wait_idle();
      chk("burst result", model, RESULT);
      chk("ready drained", 16'h0001, {15'h0000, BYTE_READY});
   endtask : burst

   task automatic reset_values();
      chk("reset result", 16'h0000, RESULT);
      chk("reset ready", 16'h0001, {15'h0000, BYTE_READY});
      chk("reset busy", 16'h0000, {15'h0000, BUSY});
   endtask : reset_values

   // Pre-reversed 80 C4 gives the reversed remainders 1189 and 0A41
   task automatic known_vector();
      seed(16'h0000);
      one_byte(8'h01);
      chk("vector one", 16'h1189, RESULT);
      one_byte(8'h23);
      chk("vector two", 16'h0A41, RESULT);
   endtask : known_vector

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      RST_N = 1'b0;
      SEED_WR = '0;
      BYTE_WR = '0;
      model = 16'h0000;
      repeat (4) @(posedge MCLK);
      #1;
      RST_N = 1'b1;
      reset_values();
      one_byte(8'h00);
      known_vector();
      seed(16'hFFFF);
      one_byte(8'hA5);
      seed_clash(16'h4C3B);
      burst(40, 8'h3C);
      seed(16'h1D0F);
      burst(6, 8'h00);
      results();
   end
endmodule : crcb_top_tb
